// File: verilog/ips_pkg.sv
package ips_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int BUS_EVT_NS    = 128_000;
    localparam int BUS_EVT_CYC   =
        (BUS_EVT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_NS       = 1_000;
    localparam logic [7:0] WAKE_CYC =
        8'((WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] CALL_CYC = 8'h0A;

    // ************************************************************
    // Register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [7:0] IDX_BUSMODE = 8'h1F;
    localparam logic [7:0] IDX_GIE     = 8'h20;
    localparam logic [7:0] IDX_EPIE    = 8'h21;
    localparam logic [7:0] IDX_CAPCFG  = 8'h44;
    localparam logic [7:0] IDX_PSC     = 8'hFF;

    // ************************************************************
    // Status and control fields
    // ************************************************************
    localparam int PSC_PEND = 7;
    localparam int PSC_WDOG = 6;
    localparam int PSC_BUS  = 5;
    localparam int PSC_LOWV = 4;
    localparam int PSC_SUSP = 3;
    localparam int PSC_GIES = 2;
    localparam int PSC_RUN  = 0;

    // ************************************************************
    // Sources, in priority order, and vectors
    // ************************************************************
    localparam int N_SRC    = 11;
    localparam int SRC_BUS  = 0;
    localparam int SRC_T128 = 1;
    localparam int SRC_T1MS = 2;
    localparam int SRC_EP0  = 3;
    localparam int SRC_EP1  = 4;
    localparam int SRC_EP2  = 5;
    localparam int SRC_SPI  = 6;
    localparam int SRC_CAPA = 7;
    localparam int SRC_CAPB = 8;
    localparam int SRC_GPIO = 9;
    localparam int SRC_WAKE = 10;
    localparam logic [12:0] VEC_RESET = 13'h0000;
    localparam logic [12:0] VEC_BASE  = 13'h0002;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b000,
        SEQ_CALL = 3'b001,
        SEQ_SUSP = 3'b010,
        SEQ_WAKE = 3'b011,
        SEQ_HALT = 3'b100
    } ips_seq_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } ips_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } ips_apb_rsp_t;

    typedef struct packed {
        logic        valid;
        logic [12:0] pc;
        logic        carry;
        logic        zero;
    } ips_push_t;

    typedef struct packed {
        ips_seq_t          state;
        logic [7:0]        cnt;
        logic [N_SRC-1:0]  pend;
        logic [7:0]        gen;
        logic [2:0]        epen;
        logic [3:0]        cen;
        logic              mode;
        logic              gie;
        logic              wdog_f;
        logic              bus_f;
        logic              lowv_f;
        logic              susp;
        logic              run;
        logic [12:0]       vaddr;
        logic              vec_ld;
        logic              restore;
        ips_push_t         push;
        logic [31:0]       rdata;
    } ips_top_st_t;

    localparam ips_top_st_t TOP_RST = '{
        state: SEQ_IDLE, run: 1'b1, lowv_f: 1'b1, vaddr: VEC_RESET,
        default: '0};

    typedef struct packed {
        logic [15:0] cnt;
        logic        fired;
        logic        fire;
    } ips_tmr_st_t;

    localparam ips_tmr_st_t TMR_RST = '{default: '0};

    function automatic logic [3:0] prio_idx(input logic [N_SRC-1:0] req);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = N_SRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic [12:0] vec_addr(input logic [3:0] idx);
        return VEC_BASE + {8'h00, idx, 1'b0};
    endfunction

endpackage

// File: verilog/ips_evt_timer.sv
`timescale 1ns/1ps
module ips_evt_timer #(
    parameter int unsigned CYCLES = 16
) (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic cond,
    output logic      fire
);
    import ips_pkg::*;

    ips_tmr_st_t s_q;
    ips_tmr_st_t s_d;

    // One pulse per unbroken stretch of CYCLES or more cycles of the condition; a drop rearms it.
    always_comb begin
        s_d = s_q;
        s_d.fire = 1'b0;
        if (!cond) begin
            s_d.cnt = 16'h0000;
            s_d.fired = 1'b0;
        end else if (s_q.cnt != 16'(CYCLES - 1)) begin
            s_d.cnt = s_q.cnt + 16'h0001;
        end else if (!s_q.fired) begin
            s_d.fire = 1'b1;
            s_d.fired = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= TMR_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign fire = s_q.fire;

endmodule

// File: verilog/ips_top.sv
`timescale 1ns/1ps
module ips_top #(
    parameter int unsigned BUS_EVT_CYCLES = ips_pkg::BUS_EVT_CYC
) (
    input  wire logic                 CLK,
    input  wire logic                 SRST,
    input  wire ips_pkg::ips_apb_req_t APB_REQ,
    output ips_pkg::ips_apb_rsp_t      APB_RSP,
    input  wire logic                 WATCHDOG_RESET_EVENT,
    input  wire logic                 LOW_VOLTAGE_RESET,
    input  wire logic                 BROWN_OUT_RESET,
    input  wire logic                 USB_RESET_COND,
    input  wire logic                 PS2_ACT_COND,
    input  wire logic                 USB_ACTIVITY,
    input  wire logic [7:0]           SRC_EVT,
    input  wire logic [3:0]           CAP_EVT,
    input  wire logic                 INSTR_DONE,
    input  wire logic                 DISABLE_IRQ_INSTRUCTION,
    input  wire logic                 ENABLE_IRQ_INSTRUCTION,
    input  wire logic                 RETURN_FROM_IRQ_INSTRUCTION,
    input  wire logic                 STOP_INSTRUCTION,
    input  wire logic [12:0]          PC,
    input  wire logic                 CARRY_FLAG,
    input  wire logic                 ZERO_FLAG,
    output logic                      CPU_HOLD,
    output logic                      VEC_LOAD,
    output logic [12:0]               VEC_ADDR,
    output ips_pkg::ips_push_t         PUSH,
    output logic                      RESTORE,
    output logic                      GIE,
    output logic                      SUSPENDED,
    output logic                      HALTED
);
    import ips_pkg::*;

    ips_top_st_t      s_q;
    ips_top_st_t      s_d;
    logic [N_SRC-1:0] en;
    logic [N_SRC-1:0] req;
    logic [N_SRC-1:0] set;
    logic [N_SRC-1:0] clr;
    logic [3:0]       win;
    logic             svc;
    logic             wake;
    logic             any_rst;
    logic             bus_fire;
    logic             wr;
    logic             hit;
    logic [7:0]       idx;
    logic [7:0]       psc;

    // ************************************************************
    // Bus event persistence
    // ************************************************************
    ips_evt_timer #(
        .CYCLES (BUS_EVT_CYCLES)
    ) u_bus_tmr (
        .clk  (CLK),
        .srst (SRST),
        .cond (s_q.mode ? PS2_ACT_COND : USB_RESET_COND),
        .fire (bus_fire)
    );

    // ************************************************************
    // Request logic
    // ************************************************************
    always_comb begin
        en = {s_q.gen[7], s_q.gen[6], s_q.gen[5], s_q.gen[4],
              s_q.gen[3], s_q.epen, s_q.gen[2:0]};
        req = s_q.pend & en;
        win = prio_idx(req);
        any_rst = LOW_VOLTAGE_RESET | BROWN_OUT_RESET
                | WATCHDOG_RESET_EVENT;
        // A suspend write goes first; a standing request then wakes it.
        svc = (s_q.state == SEQ_IDLE) && INSTR_DONE && s_q.gie
            && (|req) && !STOP_INSTRUCTION && !any_rst
            && !(wr && idx == IDX_PSC && APB_REQ.pwdata[PSC_SUSP]);
        wake = (|req) || USB_ACTIVITY;
        set = '0;
        set[SRC_BUS]  = bus_fire;
        set[SRC_T128] = SRC_EVT[0];
        set[SRC_T1MS] = SRC_EVT[1];
        set[SRC_EP0]  = SRC_EVT[2];
        set[SRC_EP1]  = SRC_EVT[3];
        set[SRC_EP2]  = SRC_EVT[4];
        set[SRC_SPI]  = SRC_EVT[5];
        set[SRC_CAPA] = |(CAP_EVT[1:0] & s_q.cen[1:0]);
        set[SRC_CAPB] = |(CAP_EVT[3:2] & s_q.cen[3:2]);
        set[SRC_GPIO] = SRC_EVT[6];
        set[SRC_WAKE] = SRC_EVT[7];
        clr = '0;
        if (svc) begin
            clr[win] = 1'b1;
        end
        psc = '0;
        psc[PSC_PEND] = |req;
        psc[PSC_WDOG] = s_q.wdog_f;
        psc[PSC_BUS]  = s_q.bus_f;
        psc[PSC_LOWV] = s_q.lowv_f;
        psc[PSC_SUSP] = s_q.susp;
        psc[PSC_GIES] = s_q.gie;
        psc[PSC_RUN]  = s_q.run;
    end

    // ************************************************************
    // Register access
    // ************************************************************
    always_comb begin
        idx = APB_REQ.paddr[9:2];
        hit = (APB_REQ.paddr[11:10] == 2'b00)
           && (APB_REQ.paddr[1:0] == 2'b00)
           && (idx == IDX_BUSMODE || idx == IDX_GIE || idx == IDX_EPIE
               || idx == IDX_CAPCFG || idx == IDX_PSC);
        wr = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite && hit;
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        s_d = s_q;
        s_d.vec_ld = 1'b0;
        s_d.restore = 1'b0;
        s_d.push.valid = 1'b0;
        s_d.pend = (s_q.pend & ~clr) | set;

        if (DISABLE_IRQ_INSTRUCTION) begin
            s_d.gie = 1'b0;
        end else if (ENABLE_IRQ_INSTRUCTION) begin
            s_d.gie = 1'b1;
        end else if (RETURN_FROM_IRQ_INSTRUCTION) begin
            s_d.gie = 1'b1;
            s_d.restore = 1'b1;
        end

        if (APB_REQ.psel && !APB_REQ.penable && !APB_REQ.pwrite) begin
            s_d.rdata = 32'h0000_0000;
            if (idx == IDX_BUSMODE) begin
                s_d.rdata[0] = s_q.mode;
            end else if (idx == IDX_GIE) begin
                s_d.rdata[7:0] = s_q.gen;
            end else if (idx == IDX_EPIE) begin
                s_d.rdata[2:0] = s_q.epen;
            end else if (idx == IDX_CAPCFG) begin
                s_d.rdata[3:0] = s_q.cen;
            end else if (idx == IDX_PSC) begin
                s_d.rdata[7:0] = psc;
            end
        end

        if (wr) begin
            if (idx == IDX_BUSMODE) begin
                s_d.mode = APB_REQ.pwdata[0];
            end else if (idx == IDX_GIE) begin
                s_d.gen = APB_REQ.pwdata[7:0];
            end else if (idx == IDX_EPIE) begin
                s_d.epen = APB_REQ.pwdata[2:0];
            end else if (idx == IDX_CAPCFG) begin
                s_d.cen = APB_REQ.pwdata[3:0];
            end else if (idx == IDX_PSC) begin
                // Bit 2 is the global flag's mirror; writes leave it.
                s_d.wdog_f = APB_REQ.pwdata[PSC_WDOG];
                s_d.bus_f = APB_REQ.pwdata[PSC_BUS];
                s_d.lowv_f = APB_REQ.pwdata[PSC_LOWV];
                s_d.run = APB_REQ.pwdata[PSC_RUN];
                if (APB_REQ.pwdata[PSC_SUSP] &&
                    s_q.state == SEQ_IDLE) begin
                    s_d.susp = 1'b1;
                    s_d.state = SEQ_SUSP;
                end
            end
        end
        // Hardware set wins over a firmware clear in the same cycle.
        if (bus_fire) begin
            s_d.bus_f = 1'b1;
        end

        case (s_q.state)
            SEQ_IDLE: begin
                if (svc) begin
                    s_d.gie = 1'b0;
                    s_d.state = SEQ_CALL;
                    s_d.cnt = CALL_CYC - 8'h01;
                    s_d.vaddr = vec_addr(win);
                    s_d.push.valid = 1'b1;
                    s_d.push.pc = PC;
                    s_d.push.carry = CARRY_FLAG;
                    s_d.push.zero = ZERO_FLAG;
                end else if (STOP_INSTRUCTION) begin
                    s_d.run = 1'b0;
                    s_d.state = SEQ_HALT;
                end
            end
            SEQ_CALL: begin
                if (s_q.cnt == 8'h00) begin
                    s_d.state = SEQ_IDLE;
                    s_d.vec_ld = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end
            end
            SEQ_SUSP: begin
                // Entered at least one cycle even if wake stands ready.
                if (wake) begin
                    s_d.state = SEQ_WAKE;
                    s_d.cnt = WAKE_CYC - 8'h01;
                end
            end
            SEQ_WAKE: begin
                if (s_q.cnt == 8'h00) begin
                    s_d.state = SEQ_IDLE;
                    s_d.susp = 1'b0;
                end else begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end
            end
            SEQ_HALT: begin
                s_d.state = SEQ_HALT;
            end
            default: begin
                s_d.state = SEQ_IDLE;
            end
        endcase

        // Low voltage first so that a coincident watchdog lands on top.
        if (LOW_VOLTAGE_RESET || BROWN_OUT_RESET) begin
            s_d = TOP_RST;
            s_d.bus_f = bus_fire;
        end
        if (WATCHDOG_RESET_EVENT) begin
            s_d.state = SEQ_IDLE;
            s_d.pend = '0;
            s_d.gen = '0;
            s_d.epen = '0;
            s_d.cen = '0;
            s_d.gie = 1'b0;
            s_d.wdog_f = 1'b1;
            s_d.bus_f = 1'b0;
            s_d.susp = 1'b0;
            s_d.run = 1'b1;
            s_d.vaddr = VEC_RESET;
            s_d.push.valid = 1'b0;
            s_d.vec_ld = 1'b0;
            s_d.restore = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            s_q <= TOP_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign APB_RSP.prdata = s_q.rdata;
    assign APB_RSP.pready = APB_REQ.penable;
    assign APB_RSP.pslverr = APB_REQ.psel && APB_REQ.penable && !hit;
    assign CPU_HOLD = (s_q.state != SEQ_IDLE);
    assign VEC_LOAD = s_q.vec_ld;
    assign VEC_ADDR = s_q.vaddr;
    assign PUSH = s_q.push;
    assign RESTORE = s_q.restore;
    assign GIE = s_q.gie;
    assign SUSPENDED = s_q.susp;
    assign HALTED = (s_q.state == SEQ_HALT);

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    property p_call_len;
        $rose(s_q.state == SEQ_CALL) |->
            ##9 (s_q.state == SEQ_CALL) ##1 VEC_LOAD;
    endproperty
    a_call_len: assert property (p_call_len) else $error("call length");

    property p_svc;
        (svc && !set[win]) |=> !GIE && PUSH.valid && !s_q.pend[$past(win)];
    endproperty
    a_svc: assert property (p_svc) else $error("service order");

    property p_hold;
        (!svc && !any_rst && !LOW_VOLTAGE_RESET && !BROWN_OUT_RESET) |=>
            ((s_q.pend & $past(s_q.pend)) == $past(s_q.pend));
    endproperty
    a_hold: assert property (p_hold) else $error("pending lost");

    property p_capa;
        (CAP_EVT[0] && s_q.cen[0] && !any_rst) |=> s_q.pend[SRC_CAPA];
    endproperty
    a_capa: assert property (p_capa) else $error("capture A lost");

    property p_gie_on;
        (ENABLE_IRQ_INSTRUCTION && !DISABLE_IRQ_INSTRUCTION && !svc
         && !any_rst) |=> GIE;
    endproperty
    a_gie_on: assert property (p_gie_on) else $error("enable failed");

    property p_stop;
        (STOP_INSTRUCTION && s_q.state == SEQ_IDLE && !svc && !any_rst
         && !wr) |=> HALTED && !s_q.run;
    endproperty
    a_stop: assert property (p_stop) else $error("stop failed");

    property p_wdog;
        (WATCHDOG_RESET_EVENT && !LOW_VOLTAGE_RESET && !BROWN_OUT_RESET)
            |=> s_q.wdog_f && s_q.run && s_q.pend == '0
                && s_q.lowv_f == $past(s_q.lowv_f);
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog load");

    property p_lowv;
        (LOW_VOLTAGE_RESET && !WATCHDOG_RESET_EVENT) |=>
            s_q.lowv_f && s_q.run && !s_q.wdog_f && !GIE && s_q.gen == '0;
    endproperty
    a_lowv: assert property (p_lowv) else $error("low voltage load");

    property p_bus;
        (bus_fire && !any_rst) |=> s_q.bus_f && s_q.pend[SRC_BUS];
    endproperty
    a_bus: assert property (p_bus) else $error("bus event lost");

    property p_susp;
        (wr && idx == IDX_PSC && APB_REQ.pwdata[PSC_SUSP] && USB_ACTIVITY
         && s_q.state == SEQ_IDLE && !any_rst && !LOW_VOLTAGE_RESET
         && !BROWN_OUT_RESET) |=> (s_q.state == SEQ_SUSP) ##1
            (s_q.state == SEQ_WAKE || !USB_ACTIVITY);
    endproperty
    a_susp: assert property (p_susp) else $error("suspend entry");

endmodule

// File: testbench/ips_cpu_model.sv
`timescale 1ns/1ps
module ips_cpu_model (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        cpu_hold,
    output logic             instr_done,
    output logic [12:0]      pc,
    output logic             carry,
    output logic             zero
);
    // ************************************************************
    // Core sequencer
    // ************************************************************
    // Every instruction takes one cycle, so a service starts at once.
    // Handler code saves the accumulator itself; it is not modelled.
    assign pc    = 13'h0123;
    assign carry = 1'b1;
    assign zero  = 1'b0;
    always @(posedge clk) begin
        instr_done <= !srst && !cpu_hold;
    end
endmodule

// File: testbench/tb.sv
`timescale 1ns/1ps
module tb;
    import ips_pkg::*;
    localparam logic [11:0] A_GIE = 12'h080;
    localparam logic [11:0] A_CAP = 12'h110;
    localparam logic [11:0] A_PSC = 12'h3FC;
    localparam logic [11:0] A_MOD = 12'h07C;
    localparam logic [11:0] A_EPN = 12'h084;
    logic         clk, srst, usb_rst, usb_act, hold, vld, rest, gie;
    logic         susp, halt, idone, cy, zr, e, ps2;
    logic [6:0]   ctl;
    logic [7:0]   src;
    logic [3:0]   cap;
    logic [12:0]  pc, vaddr;
    logic [31:0]  q;
    ips_apb_req_t req;
    ips_apb_rsp_t rsp;
    ips_push_t    push;
    int           error_cnt, checked;

    ips_top #(.BUS_EVT_CYCLES(8)) dut (
        .CLK(clk), .SRST(srst), .APB_REQ(req), .APB_RSP(rsp),
        .WATCHDOG_RESET_EVENT(ctl[0]), .LOW_VOLTAGE_RESET(ctl[1]),
        .BROWN_OUT_RESET(ctl[2]), .USB_RESET_COND(usb_rst),
        .PS2_ACT_COND(ps2), .USB_ACTIVITY(usb_act), .SRC_EVT(src),
        .CAP_EVT(cap), .INSTR_DONE(idone),
        .DISABLE_IRQ_INSTRUCTION(ctl[3]),
        .ENABLE_IRQ_INSTRUCTION(ctl[4]),
        .RETURN_FROM_IRQ_INSTRUCTION(ctl[5]),
        .STOP_INSTRUCTION(ctl[6]), .PC(pc), .CARRY_FLAG(cy),
        .ZERO_FLAG(zr), .CPU_HOLD(hold), .VEC_LOAD(vld),
        .VEC_ADDR(vaddr), .PUSH(push), .RESTORE(rest), .GIE(gie),
        .SUSPENDED(susp), .HALTED(halt));
    ips_cpu_model cpu (
        .clk(clk), .srst(srst), .cpu_hold(hold), .instr_done(idone),
        .pc(pc), .carry(cy), .zero(zr));

    // ************************************************************
    // Bus and check tasks
    // ************************************************************
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x) begin
            error_cnt++;
            $display("Error %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, {24'h00_0000, d}};
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (rsp.pready !== 1'b1);
        q = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] x);
        apb(1'b0, a, 8'h00);
        chk(q, {24'h00_0000, x});
    endtask
    // Bit order of ctl: watchdog, low voltage, brown-out, disable,
    // enable, return, stop.
    task automatic pulse(input int b);
        @(posedge clk);
        ctl[b] <= 1'b1;
        @(posedge clk);
        ctl[b] <= 1'b0;
    endtask
    task automatic evt(input logic [7:0] s, input logic [3:0] c);
        @(posedge clk);
        src <= s;
        cap <= c;
        @(posedge clk);
        src <= '0;
        cap <= '0;
    endtask
    task automatic svc(input logic [12:0] v);
        int n;
        n = 0;
        while (push.valid !== 1'b1) @(posedge clk);
        chk(gie, 0);
        chk(push, {1'b1, 13'h0123, 1'b1, 1'b0});
        while (vld !== 1'b1) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n), 10);
        chk(vaddr, v);
    endtask
    task automatic wake;
        while (susp !== 1'b0) @(posedge clk);
    endtask
    task automatic give_verdict;
        if (error_cnt == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // The tests need under 2,000 cycles; this leaves a wide margin.
    initial begin
        #200_000;
        error_cnt++;
        give_verdict();
    end
    initial begin
        {srst, usb_rst, usb_act, ps2, ctl, src, cap, req} = '0;
        srst = 1'b1;
        error_cnt = 0;
        checked = 0;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        rd(A_PSC, 8'h11);
        rd(A_GIE, 8'h00);
        apb(1'b0, 12'h008, 8'h00);
        chk(q, 32'h0000_0000);
        chk(32'(e), 32'h0000_0001);
        wr_gie: apb(1'b1, A_GIE, 8'h06);
        pulse(4);
        evt(8'h03, 4'h0);
        svc(13'h0004);
        pulse(5);
        @(posedge clk);
        chk({rest, gie}, 2'b11);
        svc(13'h0006);
        apb(1'b1, A_MOD, 8'h01);
        rd(A_MOD, 8'h01);
        apb(1'b1, A_EPN, 8'h02);
        rd(A_EPN, 8'h02);
        apb(1'b1, A_GIE, 8'h81);
        evt(8'h88, 4'h0);
        ps2 <= 1'b1;
        repeat (12) @(posedge clk);
        ps2 <= 1'b0;
        rd(A_PSC, 8'hB1);
        pulse(4);
        svc(13'h0002);
        pulse(5);
        svc(13'h000A);
        pulse(5);
        svc(13'h0016);
        apb(1'b1, A_MOD, 8'h00);
        apb(1'b1, A_PSC, 8'h11);
        pulse(3);
        apb(1'b1, A_GIE, 8'h08);
        evt(8'h20, 4'h0);
        rd(A_PSC, 8'h91);
        apb(1'b1, A_CAP, 8'h01);
        apb(1'b1, A_GIE, 8'h10);
        rd(A_PSC, 8'h11);
        evt(8'h00, 4'h2);
        rd(A_PSC, 8'h11);
        evt(8'h00, 4'h1);
        rd(A_PSC, 8'h91);
        pulse(0);
        rd(A_PSC, 8'h51);
        rd(A_GIE, 8'h00);
        rd(A_CAP, 8'h00);
        @(posedge clk);
        usb_rst <= 1'b1;
        repeat (20) @(posedge clk);
        usb_rst <= 1'b0;
        rd(A_PSC, 8'h71);
        pulse(0);
        rd(A_PSC, 8'h51);
        apb(1'b1, A_PSC, 8'h05);
        rd(A_PSC, 8'h01);
        pulse(0);
        rd(A_PSC, 8'h41);
        pulse(2);
        rd(A_PSC, 8'h11);
        apb(1'b1, A_PSC, 8'h19);
        @(posedge clk);
        chk({susp, hold}, 2'b11);
        usb_act <= 1'b1;
        wake();
        rd(A_PSC, 8'h11);
        apb(1'b1, A_PSC, 8'h19);
        @(posedge clk);
        chk(susp, 1);
        wake();
        usb_act <= 1'b0;
        pulse(6);
        @(posedge clk);
        chk(halt, 1);
        rd(A_PSC, 8'h10);
        pulse(1);
        @(posedge clk);
        chk(halt, 0);
        rd(A_PSC, 8'h11);
        give_verdict();
    end
endmodule
